// ---- common/llrc_pkg.sv ----
// Contract
// - control bits 7:6 read zero, writes ignored
// - done high one tick, results load, restart
// - comparator mirror changes at most per tick
// - in-progress bit high during pass, powers analog
// - tempco set by calibration, writable only manual
// - short bit manual-writable; when set, low trim ignored
// - enable resets one; auto mode refuses trim writes
// - enable cleared: sequencer stops, registers drive output
// - manual high trim 4:0 drives output directly
// - high trim search spans 0x00 to 0x10
// - manual low trim 3:0 drives output directly
// - low trim search spans 0x00 to 0x08
package llrc_pkg;

    // ************************************************************
    // clocking
    // ************************************************************
    localparam int CLK_NS   = 100;
    localparam int TICK_NS  = 15625;            // 64 kHz period
    localparam int TICK_CYC = TICK_NS / CLK_NS; // rounds down
    localparam logic [7:0] TICK_LAST = 8'(TICK_CYC - 1);

    // ************************************************************
    // register map, word indices; byte address is index * 4
    // ************************************************************
    localparam int          ADDR_W   = 12;
    localparam logic [9:0]  IDX_CTRL = 10'h12F;
    localparam logic [9:0]  IDX_TLO  = 10'h130;
    localparam logic [9:0]  IDX_THI  = 10'h131;
    localparam logic [9:0]  IDX_IST  = 10'h140;
    localparam logic [9:0]  IDX_ICLR = 10'h141;
    localparam logic [9:0]  IDX_IEN  = 10'h142;

    // control field positions
    localparam int BIT_EN    = 0;
    localparam int BIT_SHORT = 1;
    localparam int BIT_TCO   = 2;
    localparam int BIT_CAL   = 3;
    localparam int BIT_COMP  = 4;
    localparam int BIT_DONE  = 5;

    // interrupt status bits
    localparam int IRQ_DONE = 0;
    localparam int IRQ_COMP = 1;

    // reset values and search limits
    localparam logic       RST_EN  = 1'b1;
    localparam logic [4:0] RST_THI = 5'h00;
    localparam logic [3:0] RST_TLO = 4'h0;
    localparam logic [4:0] HI_MAX  = 5'h10;
    localparam logic [3:0] LO_MAX  = 4'h8;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [4:0] {
        SQ_IDLE = 5'b00001,
        SQ_HI   = 5'b00010,
        SQ_LO   = 5'b00100,
        SQ_TC   = 5'b01000,
        SQ_DONE = 5'b10000
    } llrc_seq_t;

endpackage

// ---- hw/llrc_axil.sv ----
// ****************************************************************
// axi4-lite slave front end
// ****************************************************************
module llrc_axil (
    input  wire logic                        clk,
    input  wire logic                        rst,
    input  wire logic [llrc_pkg::ADDR_W-1:0] awaddr,
    input  wire logic                        awvalid,
    output logic                             awready,
    input  wire logic [31:0]                 wdata,
    input  wire logic [3:0]                  wstrb,
    input  wire logic                        wvalid,
    output logic                             wready,
    output logic [1:0]                       bresp,
    output logic                             bvalid,
    input  wire logic                        bready,
    input  wire logic [llrc_pkg::ADDR_W-1:0] araddr,
    input  wire logic                        arvalid,
    output logic                             arready,
    output logic [31:0]                      rdata,
    output logic [1:0]                       rresp,
    output logic                             rvalid,
    input  wire logic                        rready,
    output logic                             wr_en,
    output logic [9:0]                       wr_idx,
    output logic [7:0]                       wr_data,
    input  wire logic                        wr_err,
    output logic [9:0]                       rd_idx,
    input  wire logic [7:0]                  rd_data,
    input  wire logic                        rd_err
);
    import llrc_pkg::*;

    typedef struct packed {
        logic       aw_have;
        logic       w_have;
        logic       ar_have;
        logic       awready;
        logic       wready;
        logic       arready;
        logic       bvalid;
        logic [1:0] bresp;
        logic       rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic       wr_en;
        logic [9:0] wr_idx;
        logic [7:0] wr_data;
        logic       lane0;
        logic [9:0] rd_idx;
    } llrc_axs_t;

    llrc_axs_t s;
    llrc_axs_t next_s;

    // address and data are taken in either order, then one response
    always_comb begin
        next_s = s;
        next_s.wr_en = 1'b0;
        if (awvalid && s.awready) begin
            next_s.aw_have = 1'b1;
            next_s.wr_idx  = awaddr[ADDR_W-1:2];
        end
        if (wvalid && s.wready) begin
            next_s.w_have  = 1'b1;
            next_s.wr_data = wdata[7:0];
            next_s.lane0   = wstrb[0];
        end
        if (s.aw_have && s.w_have && !s.bvalid) begin
            // a write without lane 0 touches nothing
            next_s.wr_en   = s.lane0;
            next_s.bvalid  = 1'b1;
            next_s.bresp   = wr_err ? RESP_SLVERR : RESP_OKAY;
            next_s.aw_have = 1'b0;
            next_s.w_have  = 1'b0;
        end else if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (arvalid && s.arready) begin
            next_s.ar_have = 1'b1;
            next_s.rd_idx  = araddr[ADDR_W-1:2];
        end
        if (s.ar_have) begin
            next_s.rvalid  = 1'b1;
            next_s.rdata   = rd_data;
            next_s.rresp   = rd_err ? RESP_SLVERR : RESP_OKAY;
            next_s.ar_have = 1'b0;
        end else if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        // one transfer of each kind in flight at a time
        next_s.awready = !next_s.aw_have && !next_s.bvalid;
        next_s.wready  = !next_s.w_have && !next_s.bvalid;
        next_s.arready = !next_s.ar_have && !next_s.rvalid;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign awready = s.awready;
    assign wready  = s.wready;
    assign arready = s.arready;
    assign bvalid  = s.bvalid;
    assign bresp   = s.bresp;
    assign rvalid  = s.rvalid;
    assign rresp   = s.rresp;
    assign rdata   = {24'h000000, s.rdata};
    assign wr_en   = s.wr_en;
    assign wr_idx  = s.wr_idx;
    assign wr_data = s.wr_data;
    assign rd_idx  = s.rd_idx;

endmodule

// ---- hw/llrc_seq.sv ----
// ****************************************************************
// calibration sequencer, steps once per 64 khz tick
// ****************************************************************
module llrc_seq (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       tick,
    input  wire logic       enable,
    input  wire logic       comp,
    output logic [4:0]      hi,
    output logic [3:0]      lo,
    output logic            short_lo,
    output logic            tempco,
    output logic            in_prog,
    output logic            done,
    output logic            load
);
    import llrc_pkg::*;

    typedef struct packed {
        llrc_seq_t  st;
        logic [4:0] hi;
        logic [3:0] lo;
        logic       short_lo;
        logic       tempco;
        logic       in_prog;
        logic       done;
        logic       load;
    } llrc_sqs_t;

    llrc_sqs_t s;
    llrc_sqs_t next_s;

    // comp high means output still above target: raise the code
    always_comb begin
        next_s = s;
        next_s.load = 1'b0;
        if (!enable) begin
            next_s.st      = SQ_IDLE;
            next_s.in_prog = 1'b0;
            next_s.done    = 1'b0;
        end else if (tick) begin
            case (s.st)
                SQ_IDLE, SQ_DONE: begin
                    next_s.st      = SQ_HI;
                    next_s.hi      = 5'h00;
                    next_s.lo      = 4'h0;
                    next_s.short_lo = 1'b0;
                    next_s.in_prog = 1'b1;
                    next_s.done    = 1'b0;
                end
                SQ_HI: begin
                    if (comp && s.hi < HI_MAX) begin
                        next_s.hi = s.hi + 5'h01;
                    end else begin
                        next_s.st = SQ_LO;
                    end
                end
                SQ_LO: begin
                    if (comp && s.lo < LO_MAX) begin
                        next_s.lo = s.lo + 4'h1;
                    end else begin
                        next_s.st = SQ_TC;
                    end
                end
                SQ_TC: begin
                    // no low step needed: bypass the lower circuit
                    next_s.tempco   = comp;
                    next_s.short_lo = (s.lo == 4'h0);
                    next_s.st       = SQ_DONE;
                    next_s.in_prog  = 1'b0;
                    next_s.done     = 1'b1;
                    next_s.load     = 1'b1;
                end
                default: begin
                    next_s.st = SQ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s <= '{st: SQ_IDLE, default: '0};
        end else begin
            s <= next_s;
        end
    end

    assign hi       = s.hi;
    assign lo       = s.lo;
    assign short_lo = s.short_lo;
    assign tempco   = s.tempco;
    assign in_prog  = s.in_prog;
    assign done     = s.done;
    assign load     = s.load;

endmodule

// ---- hw/llrc_top.sv ----
// ****************************************************************
// low-leakage regulator calibration register bank
// ****************************************************************
//
// The implementer's own choice: the AXI4-Lite register port.
module llrc_top (
    input  wire logic                        REF_CLK,
    input  wire logic                        SYS_RST,
    input  wire logic [llrc_pkg::ADDR_W-1:0] S_AXI_AWADDR,
    input  wire logic                        S_AXI_AWVALID,
    output logic                             S_AXI_AWREADY,
    input  wire logic [31:0]                 S_AXI_WDATA,
    input  wire logic [3:0]                  S_AXI_WSTRB,
    input  wire logic                        S_AXI_WVALID,
    output logic                             S_AXI_WREADY,
    output logic [1:0]                       S_AXI_BRESP,
    output logic                             S_AXI_BVALID,
    input  wire logic                        S_AXI_BREADY,
    input  wire logic [llrc_pkg::ADDR_W-1:0] S_AXI_ARADDR,
    input  wire logic                        S_AXI_ARVALID,
    output logic                             S_AXI_ARREADY,
    output logic [31:0]                      S_AXI_RDATA,
    output logic [1:0]                       S_AXI_RRESP,
    output logic                             S_AXI_RVALID,
    input  wire logic                        S_AXI_RREADY,
    input  wire logic                        CAL_COMP,
    output logic [4:0]                       TRIM_HIGH,
    output logic [3:0]                       TRIM_LOW,
    output logic                             TRIM_SHORT,
    output logic                             TRIM_TEMPCO,
    output logic                             CAL_POWER,
    output logic                             IRQ
);
    import llrc_pkg::*;

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [7:0] tick_cnt;
        logic       tick;
        logic       auto_cal_enable;
        logic       short_lower_trim;
        logic       tempco_select;
        logic [4:0] trim_high;
        logic [3:0] trim_low;
        logic       cal_comparator_out;
        logic [1:0] irq_status;
        logic [1:0] irq_enable;
        logic       irq;
        logic [4:0] out_high;
        logic [3:0] out_low;
        logic       out_short;
        logic       out_tempco;
        logic       out_power;
    } llrc_top_t;

    llrc_top_t s;
    llrc_top_t next_s;

    logic       wr_en;
    logic [9:0] wr_idx;
    logic [7:0] wr_data;
    logic       wr_err;
    logic [9:0] rd_idx;
    logic [7:0] rd_data;
    logic       rd_err;
    logic [4:0] sq_hi;
    logic [3:0] sq_lo;
    logic       sq_short;
    logic       sq_tempco;
    logic       cal_in_progress;
    logic       cal_done_pulse;
    logic       sq_load;
    logic [7:0] ctrl_rd;
    logic [1:0] irq_set;

    // ************************************************************
    // bus slave
    // ************************************************************
    llrc_axil u_axil (
        .clk     (REF_CLK),
        .rst     (SYS_RST),
        .awaddr  (S_AXI_AWADDR),
        .awvalid (S_AXI_AWVALID),
        .awready (S_AXI_AWREADY),
        .wdata   (S_AXI_WDATA),
        .wstrb   (S_AXI_WSTRB),
        .wvalid  (S_AXI_WVALID),
        .wready  (S_AXI_WREADY),
        .bresp   (S_AXI_BRESP),
        .bvalid  (S_AXI_BVALID),
        .bready  (S_AXI_BREADY),
        .araddr  (S_AXI_ARADDR),
        .arvalid (S_AXI_ARVALID),
        .arready (S_AXI_ARREADY),
        .rdata   (S_AXI_RDATA),
        .rresp   (S_AXI_RRESP),
        .rvalid  (S_AXI_RVALID),
        .rready  (S_AXI_RREADY),
        .wr_en   (wr_en),
        .wr_idx  (wr_idx),
        .wr_data (wr_data),
        .wr_err  (wr_err),
        .rd_idx  (rd_idx),
        .rd_data (rd_data),
        .rd_err  (rd_err)
    );

    // ************************************************************
    // sequencer
    // ************************************************************
    llrc_seq u_seq (
        .clk      (REF_CLK),
        .rst      (SYS_RST),
        .tick     (s.tick),
        .enable   (s.auto_cal_enable),
        .comp     (CAL_COMP),
        .hi       (sq_hi),
        .lo       (sq_lo),
        .short_lo (sq_short),
        .tempco   (sq_tempco),
        .in_prog  (cal_in_progress),
        .done     (cal_done_pulse),
        .load     (sq_load)
    );

    // ************************************************************
    // read decode
    // ************************************************************
    // control image; top two bits are hard zero
    always_comb begin
        ctrl_rd            = 8'h00;
        ctrl_rd[BIT_EN]    = s.auto_cal_enable;
        ctrl_rd[BIT_SHORT] = s.short_lower_trim;
        ctrl_rd[BIT_TCO]   = s.tempco_select;
        ctrl_rd[BIT_CAL]   = cal_in_progress;
        ctrl_rd[BIT_COMP]  = s.cal_comparator_out;
        ctrl_rd[BIT_DONE]  = cal_done_pulse;
    end

    // unmapped words answer slverr with zero data
    always_comb begin
        rd_data = 8'h00;
        rd_err  = 1'b0;
        if (rd_idx == IDX_CTRL) begin
            rd_data = ctrl_rd;
        end else if (rd_idx == IDX_TLO) begin
            rd_data = {4'h0, s.trim_low};
        end else if (rd_idx == IDX_THI) begin
            rd_data = {3'h0, s.trim_high};
        end else if (rd_idx == IDX_IST) begin
            rd_data = {6'h00, s.irq_status};
        end else if (rd_idx == IDX_ICLR) begin
            rd_data = 8'h00;                            // write-only
        end else if (rd_idx == IDX_IEN) begin
            rd_data = {6'h00, s.irq_enable};
        end else begin
            rd_err = 1'b1;
        end
    end

    // write decode only flags unmapped words; refused writes are okay
    always_comb begin
        wr_err = 1'b1;
        if (wr_idx == IDX_CTRL) begin
            wr_err = 1'b0;
        end else if (wr_idx == IDX_TLO) begin
            wr_err = 1'b0;
        end else if (wr_idx == IDX_THI) begin
            wr_err = 1'b0;
        end else if (wr_idx == IDX_IST) begin
            wr_err = 1'b0;
        end else if (wr_idx == IDX_ICLR) begin
            wr_err = 1'b0;
        end else if (wr_idx == IDX_IEN) begin
            wr_err = 1'b0;
        end
    end

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_s = s;

        // 64 khz tick from the reference clock
        if (s.tick_cnt == TICK_LAST) begin
            next_s.tick_cnt = 8'h00;
            next_s.tick     = 1'b1;
        end else begin
            next_s.tick_cnt = s.tick_cnt + 8'h01;
            next_s.tick     = 1'b0;
        end

        // mirror sampled only on the tick, so it moves at most per tick
        if (s.tick) begin
            next_s.cal_comparator_out = CAL_COMP;
        end

        // software writes; trim state locked in automatic mode
        if (wr_en) begin
            if (wr_idx == IDX_CTRL) begin
                next_s.auto_cal_enable = wr_data[BIT_EN];
                if (!s.auto_cal_enable) begin
                    next_s.short_lower_trim = wr_data[BIT_SHORT];
                    next_s.tempco_select    = wr_data[BIT_TCO];
                end
            end else if (wr_idx == IDX_TLO) begin
                if (!s.auto_cal_enable) begin
                    next_s.trim_low = wr_data[3:0];
                end
            end else if (wr_idx == IDX_THI) begin
                if (!s.auto_cal_enable) begin
                    next_s.trim_high = wr_data[4:0];
                end
            end else if (wr_idx == IDX_IEN) begin
                next_s.irq_enable = wr_data[1:0];
            end
        end

        // finished pass lands in the data registers
        if (sq_load && s.auto_cal_enable) begin
            next_s.trim_high        = sq_hi;
            next_s.trim_low         = sq_lo;
            next_s.short_lower_trim = sq_short;
            next_s.tempco_select    = sq_tempco;
        end

        // sticky events; a set in the clearing cycle survives
        irq_set = 2'b00;
        irq_set[IRQ_DONE] = sq_load;
        irq_set[IRQ_COMP] = s.tick &&
                            (CAL_COMP != s.cal_comparator_out);
        if (wr_en && wr_idx == IDX_ICLR) begin
            next_s.irq_status = (s.irq_status & ~wr_data[1:0]) | irq_set;
        end else begin
            next_s.irq_status = s.irq_status | irq_set;
        end
        next_s.irq = |(next_s.irq_status & next_s.irq_enable);

        // analog drive: sequencer codes in automatic mode, else registers
        if (s.auto_cal_enable) begin
            next_s.out_high   = sq_hi;
            next_s.out_low    = sq_short ? 4'h0 : sq_lo;
            next_s.out_short  = sq_short;
            next_s.out_tempco = sq_tempco;
        end else begin
            next_s.out_high   = s.trim_high;
            next_s.out_short  = s.short_lower_trim;
            next_s.out_tempco = s.tempco_select;
            // low code is parked at zero while the short is closed
            next_s.out_low    = s.short_lower_trim ? 4'h0
                                                   : s.trim_low;
        end
        next_s.out_power = cal_in_progress;
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge REF_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            s <= '0;
            s.auto_cal_enable <= RST_EN;
            s.trim_high       <= RST_THI;
            s.trim_low        <= RST_TLO;
            s.out_high        <= RST_THI;
            s.out_low         <= RST_TLO;
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************
    // outputs, all straight from flops
    // ************************************************************
    assign TRIM_HIGH   = s.out_high;
    assign TRIM_LOW    = s.out_low;
    assign TRIM_SHORT  = s.out_short;
    assign TRIM_TEMPCO = s.out_tempco;
    assign CAL_POWER   = s.out_power;
    assign IRQ         = s.irq;

endmodule

// ---- test/llrc_cmp_model.sv ----
// ****************************************************************
// regulator comparator model
// ****************************************************************
module llrc_cmp_model (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       power,
    input  wire logic [4:0] trim_high,
    input  wire logic [4:0] target,
    output logic            comp
);
    // larger code means lower output; unpowered it wanders, never kind
    always @(posedge clk) begin
        if (rst)
            comp <= 1'h0;
        else
            comp <= power ? (trim_high < target) : ~comp;
    end
endmodule

// ---- test/llrc_props.sv ----
// ****************************************************************
// port checker for the calibration register bank
// ****************************************************************
module llrc_props (
    input  wire logic        REF_CLK,
    input  wire logic        SYS_RST,
    input  wire logic        S_AXI_AWREADY,
    input  wire logic        S_AXI_BVALID,
    input  wire logic        S_AXI_BREADY,
    input  wire logic        S_AXI_ARREADY,
    input  wire logic        S_AXI_RVALID,
    input  wire logic [31:0] S_AXI_RDATA,
    input  wire logic [1:0]  S_AXI_RRESP,
    input  wire logic [4:0]  TRIM_HIGH,
    input  wire logic [3:0]  TRIM_LOW,
    input  wire logic        TRIM_SHORT,
    input  wire logic        CAL_POWER
);
    import llrc_pkg::*;
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SYS_RST);

    // bus side: one transfer at a time, write answer drops once taken
    a_aw_blocked: assert property (S_AXI_BVALID |-> !S_AXI_AWREADY)
        else $error("write address taken with response pending");
    a_ar_blocked: assert property (S_AXI_RVALID |-> !S_AXI_ARREADY)
        else $error("read address taken with data pending");
    a_resp_taken: assert property (S_AXI_BVALID && S_AXI_BREADY |=>
        !S_AXI_BVALID)
        else $error("write response held after it was taken");
    a_err_zero: assert property (S_AXI_RVALID &&
        S_AXI_RRESP == RESP_SLVERR |-> S_AXI_RDATA == 32'h0)
        else $error("error read returned data");
    a_rdata_upper: assert property (S_AXI_RVALID |->
        S_AXI_RDATA[31:8] == 24'h0)
        else $error("read data above the byte lane");
    // analog side: search limits and pass power
    a_hi_range: assert property (CAL_POWER |-> TRIM_HIGH <= HI_MAX)
        else $error("high trim beyond search limit");
    a_lo_range: assert property (CAL_POWER |-> TRIM_LOW <= LO_MAX)
        else $error("low trim beyond search limit");
    a_short_mask: assert property (TRIM_SHORT |-> TRIM_LOW == 4'h0)
        else $error("low trim passed while shorted");
    a_pass_power: assert property ($rose(CAL_POWER) |=> CAL_POWER[*8])
        else $error("analog power dropped inside a pass");
endmodule

bind llrc_top llrc_props u_props (.*);

// ---- test/tb_top.sv ----
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin n_mismatch++; \
    $display("wrong value at %0t: %h, expected %h", $time, a, e); end end

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import llrc_pkg::*;
    // ****************************************************************
    // bench wiring
    // ****************************************************************
    logic        clk, rst, awv, wv, bry, arv, rry;
    logic        awr, wrd, bv, arr, rv, cmp, tsh, ttc, pwr, irq;
    logic [11:0] awa, ara;
    logic [31:0] wd, rdat;
    logic [4:0]  thi;
    logic [4:0]  tgt = 5'h05;
    logic [3:0]  tlo;
    logic [1:0]  bre, rre;
    logic [7:0]  v;
    int          n_mismatch = 0;
    int          num_checks = 0;
    int          k;

    llrc_top dut (.REF_CLK(clk), .SYS_RST(rst), .S_AXI_AWADDR(awa),
        .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
        .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
        .S_AXI_BRESP(bre), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
        .S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
        .S_AXI_RDATA(rdat), .S_AXI_RRESP(rre), .S_AXI_RVALID(rv),
        .S_AXI_RREADY(rry), .CAL_COMP(cmp), .TRIM_HIGH(thi),
        .TRIM_LOW(tlo), .TRIM_SHORT(tsh), .TRIM_TEMPCO(ttc),
        .CAL_POWER(pwr), .IRQ(irq));
    llrc_cmp_model model (.clk(clk), .rst(rst), .power(pwr),
        .trim_high(thi), .target(tgt), .comp(cmp));

    // 10 mhz reference clock
    initial begin
        clk = 1'h0;
        forever #50 clk = ~clk;
    end

    task automatic summarize;
        $display("checks %0d, mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // a used-up wait counts as a mismatch and ends the run
    task automatic over(input int n);
        if (k >= n) begin
            n_mismatch++;
            summarize();
        end
    endtask

    // ****************************************************************
    // axi4-lite master
    // ****************************************************************
    task automatic wr(input logic [9:0] i, input logic [7:0] d,
                      input logic [1:0] e);
        @(posedge clk);
        awa <= {i, 2'h0};
        wd <= {24'h0, d};
        awv <= 1'h1;
        wv <= 1'h1;
        bry <= 1'h1;
        for (k = 0; k < 99 && (k == 0 || awv || wv); k++) begin
            @(posedge clk);
            if (awr) awv <= 1'h0;
            if (wrd) wv <= 1'h0;
        end
        for (k = 0; k < 99 && !bv; k++) @(posedge clk);
        bry <= 1'h0;
        `CHK(bre, e)
        over(99);
        // register lands, trim outputs follow one cycle after
        repeat (3) @(posedge clk);
    endtask

    task automatic rd(input logic [9:0] i, input logic [1:0] e);
        @(posedge clk);
        ara <= {i, 2'h0};
        arv <= 1'h1;
        rry <= 1'h1;
        for (k = 0; k < 99 && !(arr && arv); k++) @(posedge clk);
        arv <= 1'h0;
        for (k = 0; k < 99 && !rv; k++) @(posedge clk);
        rry <= 1'h0;
        v = rdat[7:0];
        `CHK(rre, e)
        over(99);
    endtask

    // clear the done status, then wait for the next load
    task automatic pass;
        wr(IDX_ICLR, 8'h01, RESP_OKAY);
        for (k = 0; k < 9000 && irq !== 1'h1; k++) @(posedge clk);
        over(9000);
    endtask

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task automatic t_reset;
        rd(IDX_CTRL, RESP_OKAY);
        `CHK(v, 8'h01)
        rd(10'h3FF, RESP_SLVERR);
        `CHK(v, 8'h00)
        $display("reset test done");
    endtask

    task automatic t_auto;
        wr(IDX_IEN, 8'h01, RESP_OKAY);
        pass();
        `CHK({thi, tlo, tsh, ttc}, 11'h142)
        wr(IDX_THI, 8'h1F, RESP_OKAY);
        wr(IDX_CTRL, 8'hC5, RESP_OKAY);
        rd(IDX_THI, RESP_OKAY);
        `CHK(v, 8'h05)
        rd(IDX_CTRL, RESP_OKAY);
        `CHK(v & 8'hC7, 8'h03)
        wr(IDX_IEN, 8'h00, RESP_OKAY);
        `CHK(irq, 1'h0)
        rd(IDX_IST, RESP_OKAY);
        `CHK(v[IRQ_DONE], 1'h1)
        wr(IDX_IEN, 8'h01, RESP_OKAY);
        `CHK(irq, 1'h1)
        $display("auto test done");
    endtask

    // target above the high search limit: both searches run to their limits
    task automatic t_cap;
        tgt <= 5'h14;
        pass();
        pass();
        `CHK({thi, tlo, tsh, ttc}, {HI_MAX, LO_MAX, 2'h1})
        rd(IDX_CTRL, RESP_OKAY);
        `CHK(v & 8'h28, 8'h20)
        repeat (160) @(posedge clk);
        rd(IDX_CTRL, RESP_OKAY);
        `CHK(v & 8'h28, 8'h08)
        $display("limit test done");
    endtask

    task automatic t_manual;
        wr(IDX_CTRL, 8'h00, RESP_OKAY);
        `CHK(pwr, 1'h0)
        wr(IDX_THI, 8'h1F, RESP_OKAY);
        wr(IDX_TLO, 8'h09, RESP_OKAY);
        wr(IDX_CTRL, 8'h04, RESP_OKAY);
        `CHK({thi, tlo, tsh, ttc}, 11'h7E5)
        wr(IDX_CTRL, 8'h02, RESP_OKAY);
        `CHK(tlo, 4'h0)
        repeat (400) @(posedge clk);
        `CHK({pwr, thi}, 6'h1F)
        $display("manual test done");
    endtask

    initial begin
        {awv, wv, bry, arv, rry, awa, ara, wd} = '0;
        rst = 1'h1;
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        t_reset();
        t_auto();
        t_cap();
        t_manual();
        summarize();
    end
endmodule
